// [pkg/io_base_cfg_regs.vh]
// Address map, field positions and reset values of the base-address configuration logic
`ifndef IO_BASE_CFG_REGS_VH
`define IO_BASE_CFG_REGS_VH

// --------------------
// Bus widths
// --------------------
`define IOCFG_AW 10
`define IOCFG_DW 8

// --------------------
// Key sequence ports and base address choices
// --------------------
`define IOCFG_KEY_A_PORT 10'h229
`define IOCFG_KEY_B_PORT 10'h22B
`define IOCFG_BASE_220 10'h220
`define IOCFG_BASE_230 10'h230
`define IOCFG_BASE_240 10'h240
`define IOCFG_BASE_250 10'h250

// --------------------
// System control register ports
// --------------------
`define IOCFG_INDEX_PORT 10'h0E0
`define IOCFG_DATA_PORT 10'h0E1
`define IOCFG_LOCK_PORT 10'h0F9
`define IOCFG_UNLOCK_PORT 10'h0FB
`define IOCFG_SCR0_INDEX 8'h00
`define IOCFG_SCR0_RESET 8'h00
`define IOCFG_SCR0_CE_BIT 2

// --------------------
// Mixer ports (offsets from base) and extension register 40H
// --------------------
`define IOCFG_MIX_INDEX_OFS 4'h4
`define IOCFG_MIX_DATA_OFS 4'h5
`define IOCFG_FM_OFS_LO 4'h8
`define IOCFG_FM_OFS_HI 4'h9
`define IOCFG_EXT40_INDEX 8'h40
`define IOCFG_EXT40_FM_BIT 0
`define IOCFG_EXT40_JOY_BIT 1
`define IOCFG_EXT40_RESTART_BIT 2
`define IOCFG_EXT40_RESET 8'h00
`define IOCFG_FM_FIXED_LO 10'h388
`define IOCFG_FM_FIXED_HI 10'h38B
`define IOCFG_JOY_PORT 10'h201

`endif

// [src/io_cycle_sync.v]
// Two-flop synchroniser for host I/O pins and cycle start detection
`timescale 1ns/1ps
module io_cycle_sync #(
    parameter AW = 10,
    parameter DW = 8
) (
    // Clock and reset
    input wire core_clk,
    input wire reset,
    // Raw host pins
    input wire [AW-1:0] pin_addr,
    input wire [DW-1:0] pin_data,
    input wire pin_rd_n,
    input wire pin_wr_n,
    input wire pin_dma,
    // Synchronised cycle events
    output wire rd_evt,
    output wire wr_evt,
    output wire [AW-1:0] cyc_addr,
    output wire [DW-1:0] cyc_data,
    output wire cyc_dma
);
    reg [AW+DW+2:0] s1_ff;
    reg [AW+DW+2:0] s2_ff;
    reg rd_n_d_ff;
    reg wr_n_d_ff;

    // Address and data lead the strobe, so equal delay keeps them aligned
    always @(posedge core_clk) begin
        if (reset) begin
            s1_ff <= {(AW+DW+3){1'b1}};
            s2_ff <= {(AW+DW+3){1'b1}};
            rd_n_d_ff <= 1'b1;
            wr_n_d_ff <= 1'b1;
        end else begin
            s1_ff <= {pin_dma, pin_rd_n, pin_wr_n, pin_addr, pin_data};
            s2_ff <= s1_ff;
            rd_n_d_ff <= s2_ff[AW+DW+1];
            wr_n_d_ff <= s2_ff[AW+DW];
        end
    end

    // One pulse per strobe at its falling edge
    assign rd_evt = rd_n_d_ff & ~s2_ff[AW+DW+1];
    assign wr_evt = wr_n_d_ff & ~s2_ff[AW+DW];
    assign cyc_addr = s2_ff[AW+DW-1:DW];
    assign cyc_data = s2_ff[DW-1:0];
    assign cyc_dma = s2_ff[AW+DW+2];
endmodule // io_cycle_sync

// [src/key_seq_fsm.v]
// Read-sequence key state machine
`timescale 1ns/1ps
`include "io_base_cfg_regs.vh"
module key_seq_fsm (
    // Clock and reset
    input wire core_clk,
    input wire reset,
    // Cycle events
    input wire rd_evt,
    input wire wr_evt,
    input wire dma,
    input wire [`IOCFG_AW-1:0] addr,
    // Hold idle while enabled or in the other method
    input wire hold,
    // Key result
    output reg key_done_ff,
    output reg [1:0] key_sel_ff,
    output reg [3:0] key_state_ff
);
    localparam ST_FAIL = 4'h8;
    reg [1:0] run_ff;
    reg [3:0] nxt_state;
    reg [3:0] exp_idx;
    reg is_a;
    reg is_b;
    reg want_a;

    // Expected port per state: A=229H, B=22BH, pattern B A B A A B A
    always @* begin
        is_a = (addr == `IOCFG_KEY_A_PORT);
        is_b = (addr == `IOCFG_KEY_B_PORT);
        exp_idx = key_state_ff;
        want_a = (exp_idx == 4'h1) || (exp_idx == 4'h3) || (exp_idx == 4'h4) ||
                 (exp_idx == 4'h6);
        nxt_state = key_state_ff;
        if (rd_evt) begin
            // R4 - triple 229H restart
            if (is_a && (run_ff == 2'h2)) begin
                nxt_state = 4'h0;
            // R5 - stepwise key advance
            end else if (key_state_ff == 4'h0 && is_a) begin
                nxt_state = 4'h0;
            end else if (key_state_ff < 4'h7 && ((want_a && is_a) || (!want_a && is_b))) begin
                nxt_state = key_state_ff + 4'h1;
            end else if (key_state_ff == ST_FAIL) begin
                nxt_state = ST_FAIL;
            end else begin
                // R7 - stray read aborts
                nxt_state = ST_FAIL;
            end
        end else if (wr_evt && !dma) begin
            // R7 - non-DMA write aborts
            nxt_state = ST_FAIL;
        end
    end

    // State, 229H run length and final base selection
    always @(posedge core_clk) begin
        if (reset || hold) begin
            key_state_ff <= 4'h0;
            run_ff <= 2'h0;
            key_done_ff <= 1'b0;
            key_sel_ff <= 2'h0;
        end else begin
            key_done_ff <= 1'b0;
            if (rd_evt) begin
                run_ff <= is_a ? ((run_ff == 2'h2) ? 2'h2 : run_ff + 2'h1) : 2'h0;
            end else if (wr_evt && !dma) begin
                run_ff <= 2'h0;
            end
            // R6 - base read in state 7
            if (rd_evt && key_state_ff == 4'h7 && (addr == `IOCFG_BASE_220 ||
                addr == `IOCFG_BASE_230 || addr == `IOCFG_BASE_240 ||
                addr == `IOCFG_BASE_250)) begin
                key_done_ff <= 1'b1;
                key_sel_ff <= addr[5:4] - 2'h2;
                key_state_ff <= 4'h0;
            end else begin
                key_state_ff <= nxt_state;
            end
        end
    end
endmodule // key_seq_fsm

// [src/io_base_address_config.v]
// Software base-address configuration and I/O decode enable logic
//
// Functional notes
// R1 - After reset, disabled; only configuration cycles are decoded.
// R2 - Strap 0 selects read-key method, strap 1 selects control register method.
// R3 - Read-key mode: writing 1 to ext 40H bit 2 disables device.
// R4 - Three consecutive 229H reads restart the key sequence.
// R5 - Reads 22B,229,22B,229,229,22B,229 step through states 1 to 7.
// R6 - In state 7, read of 220/230/240/250H sets base and enables.
// R7 - Non-DMA writes or stray reads abort an unfinished sequence.
// R8 - Once enabled by key, further key sequences are ignored until disabled.
// R9 - Write to UNLOCK_PORT unlocks the system control register access.
// R10 - Write to LOCK_PORT locks and removes control register port access.
// R11 - Data of lock and unlock writes is ignored.
// R12 - Unlocked: CONFIG_INDEX_PORT is write-only index, CONFIG_DATA_PORT write-only data.
// R13 - Only index 0 selects a register; write index then data.
// R14 - Control register bit 2 high enables I/O decoding.
// R15 - Control register bits 1 and 0 select the base address.
// R16 - Host writes zero to control register bits 7 to 3.
// R17 - Hardware reset clears the whole control register.
// R18 - Base-relative synthesizer ports answer even with fixed decode off.
// R19 - Ext 40H bit 0 enables 388-38BH, bit 1 enables 201H.
// R20 - Reset clears ext 40H bits 1-0 and 7-3; mixer reset does not.
// R21 - Select codes 00..11 map to 220H, 230H, 240H, 250H.
`timescale 1ns/1ps
`include "io_base_cfg_regs.vh"
module io_base_address_config #(
    parameter AW = `IOCFG_AW,
    parameter DW = `IOCFG_DW
) (
    // Clock and reset
    input wire core_clk,
    input wire reset,

    // Configuration strap pin
    input wire config_method_strap,

    // Host I/O bus pins
    input wire [AW-1:0] io_addr,
    input wire [DW-1:0] io_data,
    input wire io_rd_n,
    input wire io_wr_n,
    input wire io_dma,

    // Configuration state
    output reg method_ff,
    output reg dev_enable_ff,
    output reg [AW-1:0] base_addr_ff,
    output reg unlocked_ff,
    output reg [3:0] key_state_ff,

    // Extension register 40H fields
    output reg fm_fixed_en_ff,
    output reg joy_en_ff,
    output reg [4:0] mpu_cfg_ff,

    // Decode hits, one pulse per host cycle
    output reg base_hit_ff,
    output reg fm_base_hit_ff,
    output reg fm_fixed_hit_ff,
    output reg joy_hit_ff
);
    // --------------------
    // Pin synchronisation
    // --------------------
    wire rd_evt;
    wire wr_evt;
    wire [AW-1:0] cyc_addr;
    wire [DW-1:0] cyc_data;
    wire cyc_dma;
    wire any_evt;

    reg strap_s1_ff;
    reg strap_s2_ff;

    // Every host pin is brought onto core_clk before it is decoded
    // Costs two edges of latency
    io_cycle_sync #(
        .AW(AW),
        .DW(DW)
    ) u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .pin_addr(io_addr),
        .pin_data(io_data),
        .pin_rd_n(io_rd_n),
        .pin_wr_n(io_wr_n),
        .pin_dma(io_dma),
        .rd_evt(rd_evt),
        .wr_evt(wr_evt),
        .cyc_addr(cyc_addr),
        .cyc_data(cyc_data),
        .cyc_dma(cyc_dma)
    );

    // Hits count reads and writes alike
    assign any_evt = rd_evt | wr_evt;

    // Strap synchroniser; the second flop feeds the method latch only
    // No reset; long reset flushes it
    always @(posedge core_clk) begin
        strap_s1_ff <= config_method_strap;
        strap_s2_ff <= strap_s1_ff;
    end

    // --------------------
    // Method selection
    // --------------------
    // R2 - strap caught at reset
    // A new strap needs a new reset
    // The method is frozen outside reset so a strap glitch cannot flip
    // the decoder mid-operation; reset must be held three edges or more.
    always @(posedge core_clk) begin
        if (reset) begin
            method_ff <= strap_s2_ff;
        end
    end

    // --------------------
    // Common address decode
    // --------------------
    wire [AW-1:0] base_now;
    wire in_base;
    wire [3:0] base_ofs;

    wire is_lock;
    wire is_unlock;
    wire is_index;
    wire is_data;

    wire is_mix_idx;
    wire is_mix_dat;

    // Fixed ports ignore the base
    wire is_fm_fixed;
    wire is_joy;

    wire wr_real;

    assign base_now = base_addr_ff;
    assign in_base = (cyc_addr[AW-1:4] == base_now[AW-1:4]);
    assign base_ofs = cyc_addr[3:0];
    // R11 - address-only decode
    assign is_lock = (cyc_addr == `IOCFG_LOCK_PORT);
    assign is_unlock = (cyc_addr == `IOCFG_UNLOCK_PORT);
    assign is_index = (cyc_addr == `IOCFG_INDEX_PORT);
    assign is_data = (cyc_addr == `IOCFG_DATA_PORT);
    assign is_mix_idx = in_base && (base_ofs == `IOCFG_MIX_INDEX_OFS);
    assign is_mix_dat = in_base && (base_ofs == `IOCFG_MIX_DATA_OFS);
    assign is_fm_fixed = (cyc_addr >= `IOCFG_FM_FIXED_LO) && (cyc_addr <= `IOCFG_FM_FIXED_HI);
    assign is_joy = (cyc_addr == `IOCFG_JOY_PORT);
    // DMA writes never touch configuration state; DMA reads still step the key machine
    assign wr_real = wr_evt & ~cyc_dma;

    // --------------------
    // Read-sequence key method
    // --------------------
    wire key_done;
    wire [1:0] key_sel;
    wire [3:0] key_state;
    wire key_hold;
    reg key_en_ff;
    reg [1:0] key_base_ff;
    reg [DW-1:0] mix_index_ff;

    wire restart_cmd;

    // R8 - enabled device ignores keys
    assign key_hold = method_ff | key_en_ff;

    key_seq_fsm u_key (
        .core_clk(core_clk),
        .reset(reset),
        .rd_evt(rd_evt),
        .wr_evt(wr_evt),
        .dma(cyc_dma),
        .addr(cyc_addr),
        .hold(key_hold),
        .key_done_ff(key_done),
        .key_sel_ff(key_sel),
        .key_state_ff(key_state)
    );

    // Restart command: ext 40H write with bit 2 set, read-key method only
    // Mixer ports need the device on
    assign restart_cmd = wr_real && dev_enable_ff && is_mix_dat && !method_ff &&
                         (mix_index_ff == `IOCFG_EXT40_INDEX) &&
                         cyc_data[`IOCFG_EXT40_RESTART_BIT];

    // Key method enable and base code
    // Restart outranks completion
    always @(posedge core_clk) begin
        if (reset) begin
            key_en_ff <= 1'b0;
            key_base_ff <= 2'h0;
        // R3 - restart disables device
        end else if (restart_cmd) begin
            key_en_ff <= 1'b0;
        // R6 - key completion enables
        end else if (key_done && !key_en_ff) begin
            key_en_ff <= 1'b1;
            key_base_ff <= key_sel;
        end
    end

    // --------------------
    // System control register method
    // --------------------
    reg [DW-1:0] scr_index_ff;
    reg [DW-1:0] scr0_ff;

    // Lock state; lock and unlock act in either state
    // Data bytes are never stored
    always @(posedge core_clk) begin
        if (reset) begin
            unlocked_ff <= 1'b0;
        end else if (method_ff && wr_real) begin
            // R9 - unlock on UNLOCK_PORT
            if (is_unlock) begin
                unlocked_ff <= 1'b1;
            // R10 - lock on LOCK_PORT
            end else if (is_lock) begin
                unlocked_ff <= 1'b0;
            end
        end
    end

    // Index and data ports; writes while locked fall on nothing
    // Index outlives lock changes
    always @(posedge core_clk) begin
        if (reset) begin
            scr_index_ff <= 8'h00;
            // R17 - reset clears register
            scr0_ff <= `IOCFG_SCR0_RESET;
        end else if (method_ff && wr_real && unlocked_ff) begin
            // R12 - index port
            if (is_index) begin
                scr_index_ff <= cyc_data;
            // R13 - only index 0
            end else if (is_data && scr_index_ff == `IOCFG_SCR0_INDEX) begin
                // Upper bits are kept as written; host keeps them zero
                scr0_ff <= cyc_data;
            end
        end
    end

    // --------------------
    // Enable and base address
    // --------------------
    reg nxt_enable;
    reg [1:0] nxt_sel;

    // Pick the active method's enable and base code
    // Strap picks one source
    always @* begin
        if (method_ff) begin
            // R14 - enable bit
            nxt_enable = scr0_ff[`IOCFG_SCR0_CE_BIT];
            // R15 - base select bits
            nxt_sel = scr0_ff[1:0];
        end else begin
            nxt_enable = key_en_ff;
            nxt_sel = key_base_ff;
        end
    end

    // R21 - code to base address
    // Base follows the code even while disabled, so the address is ready
    // on the same edge that the enable rises.
    // Decode stays off until enabled
    always @(posedge core_clk) begin
        if (reset) begin
            // R1 - disabled after reset
            dev_enable_ff <= 1'b0;
            base_addr_ff <= `IOCFG_BASE_220;
        end else begin
            dev_enable_ff <= nxt_enable;
            case (nxt_sel)
                2'h0: base_addr_ff <= `IOCFG_BASE_220;
                2'h1: base_addr_ff <= `IOCFG_BASE_230;
                2'h2: base_addr_ff <= `IOCFG_BASE_240;
                default: base_addr_ff <= `IOCFG_BASE_250;
            endcase
        end
    end

    // --------------------
    // Mixer index and extension register 40H
    // --------------------
    // Mixer index only latches when the device decodes its base
    // Index stays until rewritten
    always @(posedge core_clk) begin
        if (reset) begin
            mix_index_ff <= 8'h00;
        end else if (wr_real && dev_enable_ff && is_mix_idx) begin
            mix_index_ff <= cyc_data;
        end
    end

    // Upper field feeds the MIDI port
    // R20 - reset clears stored bits
    // Bit 2 is a command and is never stored; a mixer reset command is
    // handled elsewhere and has no path into these flops.
    always @(posedge core_clk) begin
        if (reset) begin
            fm_fixed_en_ff <= 1'b0;
            joy_en_ff <= 1'b0;
            mpu_cfg_ff <= 5'h00;
        end else if (wr_real && dev_enable_ff && is_mix_dat &&
                     mix_index_ff == `IOCFG_EXT40_INDEX) begin
            fm_fixed_en_ff <= cyc_data[`IOCFG_EXT40_FM_BIT];
            joy_en_ff <= cyc_data[`IOCFG_EXT40_JOY_BIT];
            mpu_cfg_ff <= cyc_data[7:3];
        end
    end

    // --------------------
    // Decode hits
    // --------------------
    // One edge after the event
    // R1 - hits gated by enable
    // R18 - base-relative synth independent
    // R19 - fixed synth and joystick
    always @(posedge core_clk) begin
        if (reset) begin
            base_hit_ff <= 1'b0;
            fm_base_hit_ff <= 1'b0;
            fm_fixed_hit_ff <= 1'b0;
            joy_hit_ff <= 1'b0;
        end else begin
            base_hit_ff <= any_evt && dev_enable_ff && in_base;
            fm_base_hit_ff <= any_evt && dev_enable_ff && in_base &&
                              (base_ofs == `IOCFG_FM_OFS_LO || base_ofs == `IOCFG_FM_OFS_HI);
            fm_fixed_hit_ff <= any_evt && dev_enable_ff && fm_fixed_en_ff && is_fm_fixed;
            joy_hit_ff <= any_evt && dev_enable_ff && joy_en_ff && is_joy;
        end
    end

    // Key state mirror for software visibility
    // Adds one edge of lag
    always @(posedge core_clk) begin
        if (reset) begin
            key_state_ff <= 4'h0;
        end else begin
            key_state_ff <= key_state;
        end
    end
endmodule // io_base_address_config

// [tb/io_base_address_config_props.sv]
// Concurrent checks on the base-address configuration block ports
`timescale 1ns/1ps
`include "io_base_cfg_regs.vh"
module io_base_cfg_props #(
    parameter AW = 10,
    parameter DW = 8
) (
    // Clock and reset
    input wire core_clk,
    input wire reset,
    // Host address
    input wire [AW-1:0] io_addr,
    // Configuration state
    input wire method_ff,
    input wire dev_enable_ff,
    input wire [AW-1:0] base_addr_ff,
    input wire unlocked_ff,
    input wire [3:0] key_state_ff,
    input wire fm_fixed_en_ff,
    input wire joy_en_ff,
    input wire [4:0] mpu_cfg_ff,
    // Decode hits
    input wire base_hit_ff,
    input wire fm_fixed_hit_ff,
    input wire joy_hit_ff
);
    // --------------------
    // Clocking
    // --------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // --------------------
    // Assertions
    // --------------------
    // Hits land three edges after the strobe falls; address is three back
    AST_RESET_VALUES: assert property ($fell(reset) |-> !dev_enable_ff && !unlocked_ff
        && base_addr_ff == `IOCFG_BASE_220 && key_state_ff == 4'h0
        && {mpu_cfg_ff, joy_en_ff, fm_fixed_en_ff} == 7'h00) else $error("reset state wrong");
    AST_BASE_LEGAL: assert property (base_addr_ff inside {`IOCFG_BASE_220, `IOCFG_BASE_230,
        `IOCFG_BASE_240, `IOCFG_BASE_250}) else $error("base address out of set");
    AST_METHOD_STABLE: assert property (!$past(reset) |-> $stable(method_ff))
        else $error("method changed outside reset");
    AST_UNLOCK_SCR_ONLY: assert property (unlocked_ff |-> method_ff)
        else $error("unlocked in read-key mode");
    AST_KEY_HELD_SCR: assert property (method_ff |-> key_state_ff == 4'h0)
        else $error("key machine moved in register mode");
    AST_KEY_IDLE_ENABLED: assert property ((dev_enable_ff && !method_ff)[*3] |-> key_state_ff == 4'h0)
        else $error("key machine active while enabled");
    AST_HIT_PULSE: assert property (base_hit_ff |=> !base_hit_ff)
        else $error("base hit longer than one cycle");
    AST_BASE_HIT_ENABLED: assert property (base_hit_ff |-> dev_enable_ff
        && $past(io_addr, 3) >> 4 == base_addr_ff >> 4) else $error("base hit wrong");
    AST_JOY_HIT: assert property (joy_hit_ff |-> (joy_en_ff || $past(joy_en_ff))
        && $past(io_addr, 3) == `IOCFG_JOY_PORT) else $error("joystick hit wrong");
    AST_FM_FIXED_HIT: assert property (fm_fixed_hit_ff |-> (fm_fixed_en_ff || $past(fm_fixed_en_ff))
        && $past(io_addr, 3) inside {[`IOCFG_FM_FIXED_LO:`IOCFG_FM_FIXED_HI]})
        else $error("fixed synth hit wrong");
    AST_UNLOCK_SETS: assert property ($rose(unlocked_ff) |-> $past(io_addr, 3) == `IOCFG_UNLOCK_PORT)
        else $error("unlock without unlock port write");
    AST_LOCK_CLEARS: assert property ($fell(unlocked_ff) |-> $past(reset)
        || $past(io_addr, 3) == `IOCFG_LOCK_PORT) else $error("lock without lock port write");

    // --------------------
    // Coverage
    // --------------------
    COV_KEY_ENABLE: cover property ($rose(dev_enable_ff) && !method_ff);
    COV_SCR_ENABLE: cover property ($rose(dev_enable_ff) && method_ff);
    COV_JOY_HIT: cover property (joy_hit_ff);
    COV_FM_HIT: cover property (fm_fixed_hit_ff);
endmodule // io_base_cfg_props

bind io_base_address_config io_base_cfg_props #(.AW(AW), .DW(DW)) props_u (
    .core_clk(core_clk), .reset(reset), .io_addr(io_addr), .method_ff(method_ff),
    .dev_enable_ff(dev_enable_ff), .base_addr_ff(base_addr_ff), .unlocked_ff(unlocked_ff),
    .key_state_ff(key_state_ff), .fm_fixed_en_ff(fm_fixed_en_ff), .joy_en_ff(joy_en_ff),
    .mpu_cfg_ff(mpu_cfg_ff), .base_hit_ff(base_hit_ff), .fm_fixed_hit_ff(fm_fixed_hit_ff),
    .joy_hit_ff(joy_hit_ff)
);

// [tb/host_io_model.sv]
// Host processor model issuing I/O read and write cycles
`timescale 1ns/1ps
`include "io_base_cfg_regs.vh"
module host_io_model (
    // Clock
    input wire core_clk,
    // Host I/O bus
    output logic [`IOCFG_AW-1:0] io_addr,
    output logic [`IOCFG_DW-1:0] io_data,
    output logic io_rd_n,
    output logic io_wr_n,
    output logic io_dma
);
    // --------------------
    // Bus idle at time zero
    // --------------------
    initial begin
        io_addr = '0;
        io_data = '0;
        io_rd_n = 1'b1;
        io_wr_n = 1'b1;
        io_dma = 1'b0;
    end

    // One host cycle; strobe low four edges since the device needs three
    task automatic cyc(input bit wr, input [`IOCFG_AW-1:0] a, input [`IOCFG_DW-1:0] d,
                       input bit dm);
        @(posedge core_clk);
        #1;
        io_addr = a;
        io_data = d;
        io_dma = dm;
        @(posedge core_clk);
        #1;
        if (wr) io_wr_n = 1'b0;
        else io_rd_n = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        io_rd_n = 1'b1;
        io_wr_n = 1'b1;
        @(posedge core_clk);
        #1;
        // No pull: released address and data lines show the inverse of their last value; DMA line goes low
        io_addr = ~a;
        io_data = ~d;
        io_dma = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
endmodule // host_io_model

// [tb/tb_top.sv]
// Self-checking testbench for the base-address configuration block
`timescale 1ns/1ps
`include "io_base_cfg_regs.vh"
module tb_top;
    localparam AW = `IOCFG_AW;
    localparam DW = `IOCFG_DW;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic strap = 1'b0;
    wire [AW-1:0] io_addr;
    wire [DW-1:0] io_data;
    wire io_rd_n, io_wr_n, io_dma;
    wire method_ff, dev_enable_ff, unlocked_ff, fm_fixed_en_ff, joy_en_ff;
    wire [AW-1:0] base_addr_ff;
    wire [3:0] key_state_ff;
    wire [4:0] mpu_cfg_ff;
    int fails = 0;
    int comparisons = 0;
    logic [AW-1:0] key_seq [10] = '{10'h229, 10'h229, 10'h229, 10'h22B, 10'h229, 10'h22B,
                                    10'h229, 10'h229, 10'h22B, 10'h229};

    `define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
        $display("mismatch %s expected %0h seen %0h", n, e, g); end end

    // --------------------
    // Clock, host and design
    // --------------------
    always #10 core_clk = ~core_clk;

    host_io_model host_u (.core_clk(core_clk), .io_addr(io_addr), .io_data(io_data),
        .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .io_dma(io_dma));

    io_base_address_config #(.AW(AW), .DW(DW)) dut_u (
        .core_clk(core_clk), .reset(reset), .config_method_strap(strap),
        .io_addr(io_addr), .io_data(io_data), .io_rd_n(io_rd_n), .io_wr_n(io_wr_n),
        .io_dma(io_dma), .method_ff(method_ff), .dev_enable_ff(dev_enable_ff),
        .base_addr_ff(base_addr_ff), .unlocked_ff(unlocked_ff), .key_state_ff(key_state_ff),
        .fm_fixed_en_ff(fm_fixed_en_ff), .joy_en_ff(joy_en_ff), .mpu_cfg_ff(mpu_cfg_ff),
        .base_hit_ff(), .fm_base_hit_ff(), .fm_fixed_hit_ff(), .joy_hit_ff());

    // --------------------
    // Tasks
    // --------------------
    task automatic do_reset(input bit s);
        @(posedge core_clk);
        #1;
        reset = 1'b1;
        strap = s;
        repeat (16) @(posedge core_clk);
        #1;
        reset = 1'b0;
    endtask

    task automatic rd(input [AW-1:0] a);
        host_u.cyc(1'b0, a, 8'h00, 1'b0);
    endtask

    task automatic wr(input [AW-1:0] a, input [DW-1:0] d);
        host_u.cyc(1'b1, a, d, 1'b0);
    endtask

    // Full key run ending with the base read; optionally checks every step
    task automatic key_run(input [AW-1:0] sel, input bit chk);
        for (int i = 0; i < 10; i++) begin
            rd(key_seq[i]);
            if (chk && i > 2) `CHK("key_state", i - 2, key_state_ff)
        end
        rd(sel);
    endtask

    task automatic conclude();
        if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog; a run needs under 3000 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        conclude();
    end

    // --------------------
    // Read-key method, then control register method
    // --------------------
    initial begin
        do_reset(1'b0);
        `CHK("dev_enable", 1'b0, dev_enable_ff)
        `CHK("base_addr", 10'h220, base_addr_ff)
        `CHK("ext40", 7'h00, {mpu_cfg_ff, joy_en_ff, fm_fixed_en_ff})
        `CHK("method", 1'b0, method_ff)
        wr(`IOCFG_UNLOCK_PORT, 8'h5A);
        `CHK("unlocked", 1'b0, unlocked_ff)
        // A plain write in mid-sequence kills it, a DMA write does not
        for (int i = 0; i < 5; i++) rd(key_seq[i]);
        wr(10'h300, 8'h00);
        `CHK("key_state", 4'h8, key_state_ff)
        for (int i = 0; i < 4; i++) rd(key_seq[i]);
        host_u.cyc(1'b1, 10'h300, 8'h00, 1'b1);
        `CHK("key_state", 4'h1, key_state_ff)
        rd(10'h300);
        `CHK("key_state", 4'h8, key_state_ff)
        key_run(`IOCFG_BASE_240, 1'b1);
        `CHK("dev_enable", 1'b1, dev_enable_ff)
        `CHK("base_addr", 10'h240, base_addr_ff)
        key_run(`IOCFG_BASE_250, 1'b0);
        `CHK("base_addr", 10'h240, base_addr_ff)
        wr(10'h244, `IOCFG_EXT40_INDEX);
        wr(10'h245, 8'h1B);
        `CHK("ext40", 7'h0F, {mpu_cfg_ff, joy_en_ff, fm_fixed_en_ff})
        rd(`IOCFG_JOY_PORT);
        rd(`IOCFG_FM_FIXED_LO);
        rd(10'h248);
        wr(10'h244, `IOCFG_EXT40_INDEX);
        wr(10'h245, 8'h04);
        `CHK("dev_enable", 1'b0, dev_enable_ff)
        key_run(`IOCFG_BASE_230, 1'b0);
        `CHK("dev_enable", 1'b1, dev_enable_ff)
        `CHK("base_addr", 10'h230, base_addr_ff)
        do_reset(1'b1);
        `CHK("method", 1'b1, method_ff)
        `CHK("dev_enable", 1'b0, dev_enable_ff)
        wr(`IOCFG_INDEX_PORT, 8'h00);
        wr(`IOCFG_DATA_PORT, 8'h05);
        `CHK("dev_enable", 1'b0, dev_enable_ff)
        key_run(`IOCFG_BASE_220, 1'b0);
        `CHK("dev_enable", 1'b0, dev_enable_ff)
        wr(`IOCFG_UNLOCK_PORT, 8'hA5);
        `CHK("unlocked", 1'b1, unlocked_ff)
        // Every select code, reserved bits kept at zero
        for (int s = 0; s < 4; s++) begin
            wr(`IOCFG_INDEX_PORT, `IOCFG_SCR0_INDEX);
            wr(`IOCFG_DATA_PORT, 8'h04 | s[7:0]);
            `CHK("dev_enable", 1'b1, dev_enable_ff)
            `CHK("base_addr", 10'h220 + 10'(s * 16), base_addr_ff)
        end
        wr(`IOCFG_INDEX_PORT, 8'h01);
        wr(`IOCFG_DATA_PORT, 8'h06);
        `CHK("base_addr", 10'h250, base_addr_ff)
        wr(`IOCFG_INDEX_PORT, 8'h00);
        wr(`IOCFG_DATA_PORT, 8'h02);
        `CHK("dev_enable", 1'b0, dev_enable_ff)
        wr(`IOCFG_LOCK_PORT, 8'hC3);
        `CHK("unlocked", 1'b0, unlocked_ff)
        wr(`IOCFG_INDEX_PORT, 8'h00);
        wr(`IOCFG_DATA_PORT, 8'h07);
        `CHK("dev_enable", 1'b0, dev_enable_ff)
        wr(`IOCFG_UNLOCK_PORT, 8'h00);
        wr(`IOCFG_INDEX_PORT, 8'h00);
        wr(`IOCFG_DATA_PORT, 8'h07);
        `CHK("dev_enable", 1'b1, dev_enable_ff)
        do_reset(1'b1);
        `CHK("dev_enable", 1'b0, dev_enable_ff)
        `CHK("base_addr", 10'h220, base_addr_ff)
        `CHK("unlocked", 1'b0, unlocked_ff)
        conclude();
    end
endmodule // tb_top
